// ==== src/slb_map.svh ====
// Constants for the serial link buffer controller.
`ifndef SLB_MAP_SVH
`define SLB_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SLB_REG_CTRL        4'h0
`define SLB_REG_STATUS      4'h1
`define SLB_REG_TX_LEN      4'h2
`define SLB_REG_RX_COUNT    4'h3
`define SLB_REG_RX_ABORTS   4'h4
`define SLB_REG_IDS         4'h5
`define SLB_REG_REMOTE      4'h6
`define SLB_REG_TX_COUNT    4'h7
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define SLB_CTRL_TX_GO      0
`define SLB_CTRL_MODE_LO    1
`define SLB_CTRL_MODE_HI    2
`define SLB_CTRL_RX_EN      3
`define SLB_CTRL_TX_ABORT   4
`define SLB_CTRL_TFC_EN     5
`define SLB_CTRL_RESET      6'h00
`define SLB_FREE_MAX        6'h1E
`define SLB_FREE_ONES       6'h3F
`define SLB_FREE_ONE        6'h01
`define SLB_RECV_FC         6'h3F
`define SLB_MODE_COUNT      2'h0
`define SLB_MODE_SINGLE     2'h1
`define SLB_MODE_RECV_FC    2'h2
`define SLB_LEN_RESET       8'h04
`define SLB_ID_ZERO         6'h00
`endif

// ==== src/slb_pkg.sv ====
// Types for the serial link buffer controller.
package slb_pkg;
  typedef enum logic [1:0] {
    SLB_TX_IDLE = 2'b00,
    SLB_TX_SEND = 2'b01,
    SLB_TX_HOLD = 2'b11
  } slb_tx_state_t;
  typedef logic [5:0] slb_id_t;
endpackage : slb_pkg

// ==== src/slb_rx_sink.sv ====
// Receive stream sink: counts kept and aborted packets.
`timescale 1ns/1ps
`include "slb_map.svh"
module slb_rx_sink (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        enable_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_last_i,
  input  wire logic        rx_user_i,
  output logic             rx_ready_o,
  output logic             pkt_done_o,
  output logic [15:0]      good_count_o,
  output logic [15:0]      abort_count_o
);
  import slb_pkg::*;
  logic [15:0] good_q, good_d, abort_q, abort_d;
  logic        done_q, done_d;
  logic        beat_end;

  // The sink stalls only while its receive enable is clear, so it cannot end a received packet early.
  assign rx_ready_o = enable_i;
  assign beat_end   = rx_valid_i & rx_ready_o & rx_last_i;

  always_comb begin
    good_d  = good_q;
    abort_d = abort_q;
    done_d  = 1'b0;
    if (beat_end) begin
      done_d = 1'b1;
      if (rx_user_i) begin
        abort_d = abort_q + 16'h0001;
      end else begin
        good_d = good_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      good_q  <= 16'h0000;
      abort_q <= 16'h0000;
      done_q  <= 1'b0;
    end else begin
      good_q  <= good_d;
      abort_q <= abort_d;
      done_q  <= done_d;
    end
  end

  assign good_count_o  = good_q;
  assign abort_count_o = abort_q;
  assign pkt_done_o    = done_q;

  abort_counts_a: assert property (@(posedge clock_i) disable iff (reset_i)
    beat_end && rx_user_i |=> abort_q == $past(abort_q) + 16'h0001 && good_q == $past(good_q))
    else $error("Aborted packet not discarded.");
endmodule : slb_rx_sink

// ==== src/slb_free_count.sv ====
// Local free-buffer count generator for the three flow control modes.
`timescale 1ns/1ps
`include "slb_map.svh"
module slb_free_count (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        enable_i,
  input  wire logic        take_i,
  input  wire logic        release_i,
  output logic [5:0]       free_o
);
  import slb_pkg::*;
  logic [5:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (take_i && !release_i && cnt_q != 6'h00) begin
      cnt_d = cnt_q - 6'h01;
    end else if (release_i && !take_i && cnt_q != `SLB_FREE_MAX) begin
      cnt_d = cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cnt_q <= `SLB_FREE_MAX;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    unique case (mode_i)
      `SLB_MODE_SINGLE:  free_o = enable_i ? `SLB_FREE_ONE : 6'h00;
      `SLB_MODE_RECV_FC: free_o = `SLB_FREE_ONES;
      default:           free_o = enable_i ? cnt_q : 6'h00;
    endcase
  end

  free_range_a: assert property (@(posedge clock_i) disable iff (reset_i)
    mode_i == `SLB_MODE_COUNT |-> free_o <= `SLB_FREE_MAX)
    else $error("Free count above thirty.");
  single_bit_a: assert property (@(posedge clock_i) disable iff (reset_i)
    mode_i == `SLB_MODE_SINGLE |-> free_o[5:1] == 5'h00 && free_o[0] == enable_i)
    else $error("Single buffer mode drives upper bits.");
endmodule : slb_free_count

// ==== src/slb_ctrl.sv ====
// Buffer-side controller for a serial packet-link physical layer.
`timescale 1ns/1ps
`include "slb_map.svh"
module slb_ctrl (
  input  wire logic            clock_i,
  input  wire logic            reset_i,
  input  wire logic [3:0]      addr_i,
  input  wire logic [31:0]     wdata_i,
  input  wire logic            write_i,
  input  wire logic            read_i,
  output logic [31:0]          rdata_o,
  output logic [5:0]           local_free_o,
  input  wire logic [5:0]      remote_free_i,
  input  wire slb_pkg::slb_id_t last_ack_id_i,
  input  wire slb_pkg::slb_id_t next_transmit_id_i,
  input  wire logic            rewind_i,
  input  wire logic            link_reset_i,
  input  wire logic            rx_valid_i,
  input  wire logic [31:0]     rx_data_i,
  input  wire logic            rx_last_i,
  input  wire logic [7:0]      rx_user_i,
  output logic                 rx_ready_o,
  output logic                 tx_valid_o,
  output logic [31:0]          tx_data_o,
  output logic                 tx_last_o,
  output logic [7:0]           tx_user_o,
  input  wire logic            tx_ready_i
);
  import slb_pkg::*;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [6:0]  ctrl_q, ctrl_d;
  logic [7:0]  len_q, len_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] good_count, abort_count;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [15:0] retry_q, retry_d;
  logic        rx_done;
  logic [1:0]  mode;

  assign mode = ctrl_q[`SLB_CTRL_MODE_HI:`SLB_CTRL_MODE_LO];

  // ----------------------------------------
  // Transmit state
  // ----------------------------------------
  slb_tx_state_t state_q, state_d;
  logic [7:0]    beat_q, beat_d;
  slb_id_t       pkt_id_q, pkt_id_d;
  logic          tx_fire, tx_end, tx_abort_beat, remote_ok, go_pulse;

  function automatic logic remote_has_room(input logic [5:0] cnt, input logic gate);
    // All ones means the partner throttles with retries instead of counts.
    remote_has_room = !gate || cnt == `SLB_RECV_FC || cnt != 6'h00;
  endfunction : remote_has_room

  assign remote_ok = remote_has_room(remote_free_i, ctrl_q[`SLB_CTRL_TFC_EN]);
  assign go_pulse  = write_i && addr_i == `SLB_REG_CTRL && wdata_i[`SLB_CTRL_TX_GO];
  assign tx_fire   = tx_valid_o && tx_ready_i;
  assign tx_end    = tx_fire && tx_last_o;
  assign tx_abort_beat = tx_end && tx_user_o[0];

  always_comb begin
    ctrl_d = ctrl_q;
    len_d  = len_q;
    if (write_i) begin
      unique case (addr_i)
        `SLB_REG_CTRL:   ctrl_d = {1'b0, wdata_i[5:1], 1'b0};
        `SLB_REG_TX_LEN: len_d  = (wdata_i[7:0] == 8'h00) ? 8'h01 : wdata_i[7:0];
        default:         ctrl_d = ctrl_q;
      endcase
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (read_i) begin
      unique case (addr_i)
        `SLB_REG_CTRL:      rdata_d = {25'h0, ctrl_q};
        `SLB_REG_STATUS:    rdata_d = {28'h0, rewind_i, link_reset_i, state_q};
        `SLB_REG_TX_LEN:    rdata_d = {24'h0, len_q};
        `SLB_REG_RX_COUNT:  rdata_d = {16'h0, good_count};
        `SLB_REG_RX_ABORTS: rdata_d = {16'h0, abort_count};
        `SLB_REG_IDS:       rdata_d = {14'h0, pkt_id_q, last_ack_id_i, next_transmit_id_i};
        `SLB_REG_REMOTE:    rdata_d = {10'h0, local_free_o, retry_q[9:0], remote_free_i};
        `SLB_REG_TX_COUNT:  rdata_d = {16'h0, tx_cnt_q};
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    state_d  = state_q;
    beat_d   = beat_q;
    pkt_id_d = pkt_id_q;
    tx_cnt_d = tx_cnt_q;
    retry_d  = retry_q;
    unique case (state_q)
      SLB_TX_IDLE: begin
        if (go_pulse && remote_ok && !rewind_i) begin
          state_d  = SLB_TX_SEND;
          beat_d   = 8'h00;
          pkt_id_d = next_transmit_id_i;
        end
      end
      SLB_TX_SEND: begin
        if (rewind_i && !tx_end) begin
          state_d = SLB_TX_HOLD;
        end else if (tx_end) begin
          state_d = SLB_TX_IDLE;
          if (tx_abort_beat || rewind_i) begin
            retry_d = retry_q + 16'h0001;
          end else begin
            tx_cnt_d = tx_cnt_q + 16'h0001;
          end
        end else if (tx_fire) begin
          beat_d = beat_q + 8'h01;
        end
      end
      SLB_TX_HOLD: begin
        if (tx_end) begin
          state_d = SLB_TX_IDLE;
          retry_d = retry_q + 16'h0001;
        end
      end
      default: state_d = SLB_TX_IDLE;
    endcase
    if (link_reset_i) begin
      state_d = SLB_TX_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_q   <= 7'h00;
      len_q    <= `SLB_LEN_RESET;
      rdata_q  <= 32'h0000_0000;
      state_q  <= SLB_TX_IDLE;
      beat_q   <= 8'h00;
      pkt_id_q <= `SLB_ID_ZERO;
      tx_cnt_q <= 16'h0000;
      retry_q  <= 16'h0000;
    end else begin
      ctrl_q   <= ctrl_d;
      len_q    <= len_d;
      rdata_q  <= rdata_d;
      state_q  <= state_d;
      beat_q   <= beat_d;
      pkt_id_q <= pkt_id_d;
      tx_cnt_q <= tx_cnt_d;
      retry_q  <= retry_d;
    end
  end

  // ----------------------------------------
  // Transmit stream outputs
  // ----------------------------------------
  // During rewind the packet is closed at once with last and abort so the hold is short.
  assign tx_valid_o = state_q != SLB_TX_IDLE;
  assign tx_last_o  = state_q == SLB_TX_HOLD || beat_q + 8'h01 >= len_q ||
                      ctrl_q[`SLB_CTRL_TX_ABORT] || rewind_i;
  assign tx_user_o  = {7'h00, state_q == SLB_TX_HOLD || rewind_i || ctrl_q[`SLB_CTRL_TX_ABORT]};
  assign tx_data_o  = {pkt_id_q, 2'h0, 16'h0000, beat_q};
  assign rdata_o    = rdata_q;

  // ----------------------------------------
  // Receive path and local free count
  // ----------------------------------------
  // Delivered data has CRCs removed except a user-defined packet's padded tail; the sink ignores the data and only counts packets.
  slb_rx_sink u_rx (
    .clock_i       (clock_i),
    .reset_i       (reset_i),
    .enable_i      (ctrl_q[`SLB_CTRL_RX_EN]),
    .rx_valid_i    (rx_valid_i),
    .rx_last_i     (rx_last_i),
    .rx_user_i     (rx_user_i[0]),
    .rx_ready_o    (rx_ready_o),
    .pkt_done_o    (rx_done),
    .good_count_o  (good_count),
    .abort_count_o (abort_count)
  );

  // Each packet taken holds a buffer until software reads the receive count.
  slb_free_count u_free (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .mode_i    (mode),
    .enable_i  (ctrl_q[`SLB_CTRL_RX_EN]),
    .take_i    (rx_done),
    .release_i (read_i && addr_i == `SLB_REG_RX_COUNT),
    .free_o    (local_free_o)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence rewind_seen_s;
    state_q == SLB_TX_SEND && rewind_i && !tx_end;
  endsequence

  rewind_hold_a: assert property (@(posedge clock_i) disable iff (reset_i || link_reset_i)
    rewind_seen_s |=> state_q == SLB_TX_HOLD && tx_valid_o && tx_last_o)
    else $error("Rewind did not close the packet.");
  abort_retry_a: assert property (@(posedge clock_i) disable iff (reset_i || link_reset_i)
    tx_abort_beat && state_q != SLB_TX_IDLE |=> retry_q == $past(retry_q) + 16'h0001 &&
    tx_cnt_q == $past(tx_cnt_q))
    else $error("Aborted packet counted as sent.");
  restart_id_a: assert property (@(posedge clock_i) disable iff (reset_i || link_reset_i)
    state_q == SLB_TX_IDLE && state_d == SLB_TX_SEND |=> pkt_id_q == $past(next_transmit_id_i))
    else $error("Packet not tagged with next transmit id.");
  gate_remote_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state_q == SLB_TX_IDLE && ctrl_q[`SLB_CTRL_TFC_EN] && remote_free_i == 6'h00 |=> state_q == SLB_TX_IDLE)
    else $error("Sent with no remote room.");
  recv_fc_a: assert property (@(posedge clock_i) disable iff (reset_i)
    mode == `SLB_MODE_RECV_FC |-> local_free_o == `SLB_FREE_ONES)
    else $error("Receiver flow control not all ones.");
  rx_no_abort_a: assert property (@(posedge clock_i) disable iff (reset_i)
    ctrl_q[`SLB_CTRL_RX_EN] |-> rx_ready_o)
    else $error("Receive path stalled.");
  link_reset_a: assert property (@(posedge clock_i) disable iff (reset_i)
    link_reset_i |=> state_q == SLB_TX_IDLE)
    else $error("Link reset ignored.");
  read_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !read_i |=> rdata_o == 32'h0000_0000)
    else $error("Read data outside read cycle.");

  // ----------------------------------------
  // Stream checks
  // ----------------------------------------
  // A started packet may only leave the bus through a handshake or a link reset.
  sequence go_taken_s;
    state_q == SLB_TX_IDLE && go_pulse && remote_ok && !rewind_i && !link_reset_i;
  endsequence

  sequence good_end_s;
    state_q == SLB_TX_SEND && tx_end && !tx_user_o[0];
  endsequence

  send_start_a: assert property (@(posedge clock_i) disable iff (reset_i)
    go_taken_s |=> state_q == SLB_TX_SEND && tx_valid_o && beat_q == 8'h00)
    else $error("Accepted go did not start a packet.");
  good_count_a: assert property (@(posedge clock_i) disable iff (reset_i || link_reset_i)
    good_end_s |=> tx_cnt_q == $past(tx_cnt_q) + 16'h0001 && retry_q == $past(retry_q))
    else $error("Completed packet not counted.");
  valid_hold_a: assert property (@(posedge clock_i) disable iff (reset_i || link_reset_i)
    tx_valid_o && !tx_ready_i |=> tx_valid_o)
    else $error("Packet dropped without handshake.");
  rewind_close_a: assert property (@(posedge clock_i) disable iff (reset_i)
    rewind_i && tx_valid_o |-> tx_last_o && tx_user_o[0])
    else $error("Rewind beat not closed with abort.");
  hold_end_a: assert property (@(posedge clock_i) disable iff (reset_i || link_reset_i)
    state_q == SLB_TX_HOLD && tx_end |=> state_q == SLB_TX_IDLE &&
    retry_q == $past(retry_q) + 16'h0001 && tx_cnt_q == $past(tx_cnt_q))
    else $error("Rewound packet not counted as retry.");
  abort_last_a: assert property (@(posedge clock_i) disable iff (reset_i)
    tx_user_o[0] |-> tx_last_o && tx_user_o[7:1] == 7'h00)
    else $error("Abort flag without last beat.");
  id_steady_a: assert property (@(posedge clock_i) disable iff (reset_i || link_reset_i)
    state_q != SLB_TX_IDLE |=> pkt_id_q == $past(pkt_id_q))
    else $error("Packet id changed mid packet.");
  remote_fc_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state_q == SLB_TX_IDLE && go_pulse && remote_free_i == `SLB_RECV_FC && !rewind_i && !link_reset_i
    |=> state_q == SLB_TX_SEND)
    else $error("All ones remote count blocked sending.");
  idle_quiet_a: assert property (@(posedge clock_i) disable iff (reset_i)
    state_q == SLB_TX_IDLE |-> !tx_valid_o)
    else $error("Valid raised outside a packet.");
  rx_closed_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !ctrl_q[`SLB_CTRL_RX_EN] && mode != `SLB_MODE_RECV_FC |-> local_free_o == 6'h00 && !rx_ready_o)
    else $error("Disabled receive path still offers buffers.");
  // A take and a release in one cycle cancel, so only a lone take is checked here.
  free_take_a: assert property (@(posedge clock_i) disable iff (reset_i)
    mode == `SLB_MODE_COUNT && ctrl_q[`SLB_CTRL_RX_EN] && !write_i && rx_done && !read_i &&
    local_free_o != 6'h00 |=> local_free_o == $past(local_free_o) - 6'h01)
    else $error("Taken packet did not use a buffer.");
endmodule : slb_ctrl

// ==== testbench/slb_phy_model.sv ====
// Behavioural physical layer model facing the buffer controller.
`timescale 1ns/1ps
module slb_phy_model (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        slow_i,
  input  wire logic        retry_i,
  input  wire logic        link_reset_i,
  input  wire logic        rx_go_i,
  input  wire logic        rx_bad_i,
  input  wire logic [5:0]  remote_i,
  input  wire logic [5:0]  local_free_i,
  output logic [5:0]       ack_status_o,
  output logic [3:0]       stomps_o,
  output logic [5:0]       remote_free_o,
  output logic [5:0]       last_ack_id_o,
  output logic [5:0]       next_transmit_id_o,
  output logic             rewind_o,
  output logic             link_reset_o,
  output logic             rx_valid_o,
  output logic [31:0]      rx_data_o,
  output logic             rx_last_o,
  output logic [7:0]       rx_user_o,
  input  wire logic        rx_ready_i,
  input  wire logic        tx_valid_i,
  input  wire logic        tx_last_i,
  input  wire logic [7:0]  tx_user_i,
  output logic             tx_ready_o
);
  logic [2:0] beat_q;
  logic       tick_q;
  logic       tx_end;
  logic       sent_q;
  // ----------------------------------------
  // Status toward the buffer
  // ----------------------------------------
  assign tx_end        = tx_valid_i && tx_ready_o && tx_last_i;
  assign remote_free_o = remote_i;
  assign link_reset_o  = link_reset_i;
  // Every outgoing acknowledgement, status or retry symbol carries this field.
  assign ack_status_o  = local_free_i;
  // Slow mode drops ready every other cycle to stretch packets.
  assign tx_ready_o = !slow_i || tick_q;
  assign rx_last_o  = rx_valid_o && beat_q == 3'h2;
  assign rx_user_o  = {7'h00, rx_last_o && rx_bad_i};
  // An idle data bus shows all ones, never the last beat.
  // Beats arrive with the CRC words already stripped.
  assign rx_data_o  = rx_valid_o ? {29'h0000000, beat_q} : {29'h1FFFFFFF, ~beat_q};
  // ----------------------------------------
  // Identifier and stream state
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    tick_q <= !tick_q;
    if (reset_i || link_reset_i) begin
      tick_q             <= 1'b0;
      next_transmit_id_o <= 6'h00;
      last_ack_id_o      <= 6'h3F;
      rewind_o           <= 1'b0;
      rx_valid_o         <= 1'b0;
      beat_q             <= 3'h0;
      sent_q             <= 1'b0;
      stomps_o           <= 4'h0;
    end else begin
      // A packet cut after some beats went out must be cancelled on the link.
      if (tx_end) begin
        sent_q <= 1'b0;
        if (tx_user_i[0] && sent_q) begin
          stomps_o <= stomps_o + 4'h1;
        end
      end else if (tx_valid_i && tx_ready_o) begin
        sent_q <= 1'b1;
      end
      // The retried packet keeps its identifier, so next id stays put.
      if (retry_i) begin
        rewind_o <= 1'b1;
      end else if (tx_end) begin
        rewind_o <= 1'b0;
      end
      if (tx_end && !tx_user_i[0] && !rewind_o) begin
        last_ack_id_o      <= next_transmit_id_o;
        next_transmit_id_o <= next_transmit_id_o + 6'h01;
      end
      if (rx_go_i) begin
        rx_valid_o <= 1'b1;
      end else if (rx_valid_o && rx_ready_i) begin
        beat_q <= rx_last_o ? 3'h0 : beat_q + 3'h1;
        rx_valid_o <= !rx_last_o;
      end
    end
  end
endmodule : slb_phy_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the buffer controller.
`timescale 1ns/1ps
`include "slb_map.svh"
module testbench;
  import slb_pkg::*;
  logic clock_i, reset_i, write_i, read_i, tx_ready, rewind, lrst_o, rx_valid, rx_last, tx_valid_o, tx_last_o;
  logic slow, retry, lrst, rx_go, rx_bad, rx_ready_o;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, rx_data, tx_data_o, d;
  logic [5:0]  local_free_o, remote_free, remote;
  logic [7:0]  rx_user, tx_user_o;
  logic [5:0]  ack_status;
  logic [3:0]  stomps;
  slb_id_t     last_ack, next_id;
  int          error_cnt, samples_checked, ab_cnt, i;
  slb_ctrl slb_ctrl_inst (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .local_free_o(local_free_o),
    .remote_free_i(remote_free), .last_ack_id_i(last_ack), .next_transmit_id_i(next_id), .rewind_i(rewind),
    .link_reset_i(lrst_o), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last), .rx_user_i(rx_user),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_user_o(tx_user_o), .tx_ready_i(tx_ready));
  slb_phy_model slb_phy_model_inst (.clock_i(clock_i), .reset_i(reset_i), .slow_i(slow), .retry_i(retry),
    .link_reset_i(lrst), .rx_go_i(rx_go), .rx_bad_i(rx_bad), .remote_i(remote), .remote_free_o(remote_free),
    .local_free_i(local_free_o), .ack_status_o(ack_status), .stomps_o(stomps),
    .last_ack_id_o(last_ack), .next_transmit_id_o(next_id), .rewind_o(rewind), .link_reset_o(lrst_o),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last), .rx_user_o(rx_user),
    .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_user_i(tx_user_o),
    .tx_ready_o(tx_ready));
  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
    @(negedge clock_i);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask : rd
  // Polling stops at the first match, so a stuck field fails after a bounded wait.
  task automatic poll(input string n, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    int k;
    for (k = 0; k < 100; k++) begin
      rd(a);
      if ((d & m) === e) break;
    end
    chk(n, e, d & m);
    if (k == 100) summarize();
  endtask : poll
  task automatic wait_ab(input int n);
    int k;
    for (k = 0; k < 200 && ab_cnt < n; k++) @(posedge clock_i);
    chk("abort_ends", n, ab_cnt);
    if (ab_cnt < n) summarize();
  endtask : wait_ab
  // ----------------------------------------
  // Stream monitor
  // ----------------------------------------
  // Sampled mid cycle, where the values that the next edge takes are settled.
  always @(negedge clock_i) begin
    if (tx_valid_o && tx_ready && tx_last_o && tx_user_o[0]) ab_cnt <= ab_cnt + 1;
    if (tx_valid_o && tx_ready && tx_data_o[7:0] == 8'h00) chk("tx_id", {26'h0, next_id}, {26'h0, tx_data_o[31:26]});
  end
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    {reset_i, write_i, read_i, slow, retry, lrst, rx_go, rx_bad} = 8'h80;
    {addr_i, wdata_i, error_cnt, samples_checked, ab_cnt} = '0;
    remote = 6'h05;
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(`SLB_REG_CTRL);
    chk("ctrl", 32'h0, d);
    rd(4'hF);
    chk("unmapped", 32'h0, d);
    chk("free_reset", 32'h0, {26'h0, local_free_o});
    poll("remote", `SLB_REG_REMOTE, 32'h3F, 32'h05);
    wr(`SLB_REG_CTRL, 32'h0000000A);
    chk("free_single", 32'h1, {26'h0, local_free_o});
    wr(`SLB_REG_CTRL, 32'h0000000C);
    chk("free_recv_fc", 32'h3F, {26'h0, local_free_o});
    wr(`SLB_REG_CTRL, 32'h00000008);
    chk("free_count", 32'h1E, {26'h0, local_free_o});
    chk("ack_status", 32'h1E, {26'h0, ack_status});
    @(posedge clock_i);
    rx_go <= 1'b1;
    @(posedge clock_i);
    rx_go <= 1'b0;
    for (i = 0; i < 100 && local_free_o !== 6'h1D; i++) @(posedge clock_i);
    chk("free_taken", 32'h1D, {26'h0, local_free_o});
    rx_bad <= 1'b1;
    rx_go <= 1'b1;
    @(posedge clock_i);
    rx_go <= 1'b0;
    poll("rx_aborts", `SLB_REG_RX_ABORTS, 32'hFFFF, 32'h1);
    rd(`SLB_REG_RX_COUNT);
    chk("rx_good", 32'h1, d & 32'hFFFF);
    wr(`SLB_REG_TX_LEN, 32'h3);
    wr(`SLB_REG_CTRL, 32'h9);
    poll("tx_count", `SLB_REG_TX_COUNT, 32'hFFFF, 32'h1);
    poll("ids_first", `SLB_REG_IDS, 32'hFFF, 32'h001);
    wr(`SLB_REG_CTRL, 32'h19);
    wait_ab(1);
    wr(`SLB_REG_CTRL, 32'h8);
    poll("ids_abort", `SLB_REG_IDS, 32'h3F, 32'h1);
    chk("no_stomp", 32'h0, {28'h0, stomps});
    slow <= 1'b1;
    wr(`SLB_REG_TX_LEN, 32'h8);
    wr(`SLB_REG_CTRL, 32'h9);
    repeat (3) @(posedge clock_i);
    retry <= 1'b1;
    @(posedge clock_i);
    retry <= 1'b0;
    wait_ab(2);
    poll("retries", `SLB_REG_REMOTE, 32'hFFC0, 32'h80);
    chk("rewind_done", 32'h0, {31'h0, rewind});
    chk("stomps", 32'h1, {28'h0, stomps});
    slow <= 1'b0;
    wr(`SLB_REG_CTRL, 32'h9);
    poll("tx_resent", `SLB_REG_TX_COUNT, 32'hFFFF, 32'h2);
    poll("ids_resent", `SLB_REG_IDS, 32'h3F, 32'h2);
    remote <= 6'h00;
    wr(`SLB_REG_CTRL, 32'h28);
    wr(`SLB_REG_CTRL, 32'h29);
    i = 0;
    repeat (20) begin
      @(posedge clock_i);
      if (tx_valid_o !== 1'b0) i++;
    end
    chk("tfc_block", 32'h0, i);
    remote <= 6'h3F;
    wr(`SLB_REG_CTRL, 32'h29);
    poll("tfc_pass", `SLB_REG_TX_COUNT, 32'hFFFF, 32'h3);
    lrst <= 1'b1;
    @(posedge clock_i);
    lrst <= 1'b0;
    poll("ids_reset", `SLB_REG_IDS, 32'hFFF, 32'hFC0);
    summarize();
  end
endmodule : testbench
